// file: rtl/drap_pkg.sv
// Function
// R1 - Pattern RAM reads and writes are refused while the access enable bit 7 is 0 and allowed when it is 1; here bits 6, 12 and 0 must also be 1.
// R2 - Written data reaches the pattern RAM only when update enable bit 6 is set with bit 7; bit 6 at 0 denies access.
// R3 - Pattern RAM access proceeds only with control bits 7 and 6 and bits 12 and 0 of the gate register all at 1.
// R4 - If any of those four bits is 0 the pattern RAM is held in power-down.
// R5 - A 6-bit address field of the control register selects the RAM location for the next data access.
// R6 - Every read or write of the data register increments the RAM address field; here refused accesses leave it unchanged.
// R7 - Software reloads the address field before each block of non-sequential accesses.
// R8 - A 32-bit read/write data register carries the word read from or written to the RAM.
// R9 - The control register resets to zero and software writes 0 to its reserved bits.
// R10 - A data register read returns the RAM word at the address held before the increment.
package drap_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int RAM_AW = 6;

  localparam logic [ADDR_W-1:0] CTRL_OFF = 12'h400;
  localparam logic [ADDR_W-1:0] WORD_OFF = 12'h404;
  localparam logic [ADDR_W-1:0] GATE_OFF = 12'h40c;

  localparam int ACCESS_BIT  = 7;
  localparam int UPDATE_BIT  = 6;
  localparam int GATE_HI_BIT = 12;
  localparam int GATE_LO_BIT = 0;

  localparam logic [7:0]        CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;
  localparam logic [1:0]        GATE_RST = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum {SEL_CTRL, SEL_WORD, SEL_GATE, SEL_NONE} drap_sel_e;
  typedef enum {RD_IDLE, RD_WAIT, RD_RESP} drap_rd_e;

  typedef struct packed {
    logic              accessEn;
    logic              writeEn;
    logic [RAM_AW-1:0] addr;
  } drap_ctrl_s;

  function automatic drap_sel_e drap_decode(input logic [ADDR_W-1:0] a);
    if (a[ADDR_W-1:2] == CTRL_OFF[ADDR_W-1:2]) begin
      return SEL_CTRL;
    end else if (a[ADDR_W-1:2] == WORD_OFF[ADDR_W-1:2]) begin
      return SEL_WORD;
    end else if (a[ADDR_W-1:2] == GATE_OFF[ADDR_W-1:2]) begin
      return SEL_GATE;
    end
    return SEL_NONE;
  endfunction : drap_decode
endpackage : drap_pkg

// file: rtl/drap_pattern_ram.sv
`timescale 1ns/1ps
`default_nettype none
module drap_pattern_ram #(
  parameter int DW = 32,
  parameter int AW = 6
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          powerDown,
  input  wire logic          re,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  // Powered-down array ignores every strobe
  always_ff @(posedge clk) begin
    if (!powerDown && we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= '0;
    end else if (!powerDown && re) begin
      rdata <= mem[addr];
    end
  end
endmodule : drap_pattern_ram
`default_nettype wire

// file: rtl/drap_top.sv
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module drap_top
  import drap_pkg::*;
#(
  parameter int RAM_ADDR_W = RAM_AW
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic      [1:0]        bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic      [DATA_W-1:0] rdata,
  output logic      [1:0]        rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   patternTablePowerDown
);
  drap_ctrl_s        ctrlQ;
  logic [1:0]        gateQ;
  logic [DATA_W-1:0] wordQ;
  logic              awHeldQ;
  logic              wHeldQ;
  logic [ADDR_W-1:0] awAddrQ;
  logic [DATA_W-1:0] wDataQ;
  logic [3:0]        wStrbQ;
  logic              bvalidQ;
  logic [1:0]        brespQ;
  drap_rd_e          rdStateQ;
  drap_sel_e         rdSelQ;
  logic              rdOkQ;
  logic [DATA_W-1:0] rdataQ;
  logic [1:0]        rrespQ;
  logic              accessOpen;
  logic              wrGo;
  logic              arFire;
  drap_sel_e         wrSel;
  drap_sel_e         arSel;
  logic              ramWe;
  logic              ramRe;
  logic [DATA_W-1:0] ramRdata;
  logic [DATA_W-1:0] wrMerged;
  logic [RAM_AW-1:0] addrNext;

  function automatic logic [DATA_W-1:0] drap_merge(input logic [DATA_W-1:0] old,
                                                   input logic [DATA_W-1:0] nw,
                                                   input logic [3:0]        strb);
    logic [DATA_W-1:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : drap_merge

  // All four enables must be high to reach the array
  assign accessOpen            = ctrlQ.accessEn & ctrlQ.writeEn & gateQ[1] & gateQ[0]; // [R1] [R2] [R3]
  assign patternTablePowerDown = ~accessOpen; // [R4]

  assign wrSel    = drap_decode(awAddrQ);
  assign arSel    = drap_decode(araddr);
  assign awready  = ~awHeldQ;
  assign wready   = ~wHeldQ;
  assign wrGo     = awHeldQ & wHeldQ & ~bvalidQ & (rdStateQ == RD_IDLE);
  // Pending write wins so only one access touches the address at a time
  assign arready  = (rdStateQ == RD_IDLE) & ~(awHeldQ & wHeldQ);
  assign arFire   = arvalid & arready;
  assign wrMerged = drap_merge(wordQ, wDataQ, wStrbQ);
  assign ramWe    = wrGo & (wrSel == SEL_WORD) & accessOpen; // [R2] [R3]
  assign ramRe    = arFire & (arSel == SEL_WORD) & accessOpen; // [R1] [R3]
  // Six-bit step wraps from the top location to zero
  assign addrNext = ctrlQ.addr + RAM_AW'(1);

  assign bvalid = bvalidQ;
  assign bresp  = brespQ;
  assign rvalid = (rdStateQ == RD_RESP);
  assign rdata  = rdataQ;
  assign rresp  = rrespQ;

  drap_pattern_ram #(
    .DW(DATA_W),
    .AW(RAM_ADDR_W)
  ) i_drap_pattern_ram (
    .clk      (clk),
    .rst_b    (rst_b),
    .powerDown(patternTablePowerDown),
    .re       (ramRe),
    .we       (ramWe),
    .addr     (ctrlQ.addr), // [R5]
    .wdata    (wrMerged),
    .rdata    (ramRdata)
  );

  // Write address and data captured independently
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeldQ <= 1'b0;
      awAddrQ <= '0;
    end else if (awvalid && awready) begin
      awHeldQ <= 1'b1;
      awAddrQ <= awaddr;
    end else if (wrGo) begin
      awHeldQ <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wHeldQ <= 1'b0;
      wDataQ <= '0;
      wStrbQ <= 4'h0;
    end else if (wvalid && wready) begin
      wHeldQ <= 1'b1;
      wDataQ <= wdata;
      wStrbQ <= wstrb;
    end else if (wrGo) begin
      wHeldQ <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bvalidQ <= 1'b0;
      brespQ  <= RESP_OKAY;
    end else if (wrGo) begin
      bvalidQ <= 1'b1;
      if (wrSel == SEL_NONE) begin
        brespQ <= RESP_DECERR;
      end else if (wrSel == SEL_WORD && !accessOpen) begin
        brespQ <= RESP_SLVERR; // [R1] [R2]
      end else begin
        brespQ <= RESP_OKAY;
      end
    end else if (bready) begin
      bvalidQ <= 1'b0;
    end
  end

  // Control register; reserved bits are not stored and read back zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlQ <= drap_ctrl_s'(CTRL_RST); // [R9]
    end else if (wrGo && wrSel == SEL_CTRL && wStrbQ[0]) begin
      ctrlQ <= drap_ctrl_s'(wDataQ[7:0]); // [R5] [R9]
    end else if (ramWe || (rdStateQ == RD_WAIT && rdSelQ == SEL_WORD && rdOkQ)) begin
      ctrlQ.addr <= addrNext; // [R6]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gateQ <= GATE_RST;
    end else if (wrGo && wrSel == SEL_GATE) begin
      if (wStrbQ[1]) begin
        gateQ[1] <= wDataQ[GATE_HI_BIT];
      end
      if (wStrbQ[0]) begin
        gateQ[0] <= wDataQ[GATE_LO_BIT];
      end
    end
  end

  // Data register holds the last word written or read
  // Refused writes still load it; only the array is gated
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wordQ <= WORD_RST;
    end else if (wrGo && wrSel == SEL_WORD) begin
      wordQ <= wrMerged; // [R8]
    end else if (rdStateQ == RD_WAIT && rdSelQ == SEL_WORD && rdOkQ) begin
      wordQ <= ramRdata; // [R8] [R10]
    end
  end

  // Read channel: accept, fetch, answer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdStateQ <= RD_IDLE;
      rdSelQ   <= SEL_NONE;
      rdOkQ    <= 1'b0;
    end else begin
      unique case (rdStateQ)
        RD_IDLE: begin
          // Gate state frozen at acceptance for the whole read
          if (arFire) begin
            rdStateQ <= RD_WAIT;
            rdSelQ   <= arSel;
            rdOkQ    <= accessOpen; // [R1] [R3]
          end
        end
        RD_WAIT: begin
          rdStateQ <= RD_RESP;
        end
        RD_RESP: begin
          if (rready) begin
            rdStateQ <= RD_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdataQ <= '0;
      rrespQ <= RESP_OKAY;
    end else if (rdStateQ == RD_WAIT) begin
      rrespQ <= RESP_OKAY;
      unique case (rdSelQ)
        SEL_CTRL: rdataQ <= {24'h0, ctrlQ};
        SEL_WORD: begin
          rdataQ <= rdOkQ ? ramRdata : wordQ; // [R10]
          if (!rdOkQ) begin
            rrespQ <= RESP_SLVERR; // [R1]
          end
        end
        SEL_GATE: begin
          rdataQ              <= '0;
          rdataQ[GATE_HI_BIT] <= gateQ[1];
          rdataQ[GATE_LO_BIT] <= gateQ[0];
        end
        SEL_NONE: begin
          rdataQ <= '0;
          rrespQ <= RESP_DECERR;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  power_gate_a: assert property (patternTablePowerDown == !(ctrlQ.accessEn && ctrlQ.writeEn && &gateQ)) // [R4]
    else $error("power-down does not follow the four enables");

  refuse_read_a: assert property (arFire && arSel == SEL_WORD && !ctrlQ.accessEn |-> // [R1]
                                  !ramRe ##2 (rvalid && rresp == RESP_SLVERR))
    else $error("read with access disabled was not refused");

  update_deny_a: assert property (wrGo && wrSel == SEL_WORD && !ctrlQ.writeEn |-> // [R2]
                                  !ramWe ##1 (bvalid && bresp == RESP_SLVERR))
    else $error("write with update disabled reached the array");

  open_gate_a: assert property ((ramWe || ramRe) |-> (&gateQ && ctrlQ.accessEn && ctrlQ.writeEn)) // [R3]
    else $error("array access with a gate bit low");

  addr_step_a: assert property (ramWe |=> ctrlQ.addr == $past(ctrlQ.addr) + 6'h01) // [R5] [R6]
    else $error("address did not advance after a data write");

  word_store_a: assert property (wrGo && wrSel == SEL_WORD && wStrbQ == 4'hf |=> wordQ == $past(wDataQ)) // [R8]
    else $error("data register did not take the written word");

  ctrl_resv_a: assert property (rvalid && rdSelQ == SEL_CTRL |-> rdata[31:8] == 24'h0) // [R9]
    else $error("reserved control bits read non-zero");

  read_order_a: assert property (ramRe |-> ##2 (rvalid && rdata == wordQ && // [R10] [R6]
                                 ctrlQ.addr == $past(ctrlQ.addr, 2) + 6'h01))
    else $error("read word or address step wrong");

  wr_no_step_a: assert property (wrGo && wrSel == SEL_WORD && !accessOpen |=> $stable(ctrlQ.addr)) // [R3]
    else $error("refused data write moved the address");

  rd_no_step_a: assert property (rdStateQ == RD_WAIT && rdSelQ == SEL_WORD && !rdOkQ |=> // [R1]
                                 $stable(ctrlQ.addr) && $stable(wordQ))
    else $error("refused data read moved the address or data register");

  rd_step_a: assert property (rdStateQ == RD_WAIT && rdSelQ == SEL_WORD && rdOkQ |=> // [R6]
                              ctrlQ.addr == $past(ctrlQ.addr) + 6'h01)
    else $error("address did not advance after a data read");

  deny_pd_a: assert property ((ramWe || ramRe) |-> !patternTablePowerDown) // [R4]
    else $error("array strobed while powered down");

  ctrl_load_a: assert property (wrGo && wrSel == SEL_CTRL && wStrbQ[0] |=> // [R5]
                                ctrlQ.addr == $past(wDataQ[RAM_AW-1:0]))
    else $error("address field did not take the written value");

  gate_load_a: assert property (wrGo && wrSel == SEL_GATE && wStrbQ[1] |=> // [R3]
                                gateQ[1] == $past(wDataQ[GATE_HI_BIT]))
    else $error("gate bit 12 did not take the written value");

  merge_keep_a: assert property (wrGo && wrSel == SEL_WORD && wStrbQ == 4'h1 |=> // [R8]
                                 wordQ == {$past(wordQ[31:8]), $past(wDataQ[7:0])})
    else $error("partial write did not merge into the data register");

  wr_ok_a: assert property (wrGo && wrSel == SEL_WORD && accessOpen |=> (bvalid && bresp == RESP_OKAY)) // [R2]
    else $error("allowed data write not answered OKAY");

  allowed_write_c: cover property (ramWe);
  allowed_read_c:  cover property (ramRe ##2 rvalid);
  refused_read_c:  cover property (rvalid && rresp == RESP_SLVERR);
  ctrl_write_c:    cover property (wrGo && wrSel == SEL_CTRL);
  partial_strobe_c: cover property (wrGo && wrSel == SEL_WORD && wStrbQ != 4'hf);
endmodule : drap_top
`default_nettype wire

// file: testbench/drap_testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import drap_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic              awvalid = 1'b0;
  logic              awready;
  logic [DATA_W-1:0] wdata = '0;
  logic [3:0]        wstrb = 4'h0;
  logic              wvalid = 1'b0;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              bready = 1'b0;
  logic [ADDR_W-1:0] araddr = '0;
  logic              arvalid = 1'b0;
  logic              arready;
  logic [DATA_W-1:0] rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              rready = 1'b0;
  logic              patternTablePowerDown;
  int                miscompares = 0;
  int                total_checks = 0;
  int                cycles = 0;
  logic [1:0]        resp;
  logic [DATA_W-1:0] rd;
  logic [3:0]        strbSel = 4'hf;

  drap_top #(.RAM_ADDR_W(RAM_AW)) i_drap_top (
    .clk(clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .patternTablePowerDown(patternTablePowerDown)
  );

  always #4 clk = ~clk;

  task automatic end_sim();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // Hang guard well above the roughly 150 cycles the scenarios need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= strbSel;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr

  task automatic t_reset();
    axr(CTRL_OFF, rd, resp);
    chk("ctrl reset", 32'h0000_0000, rd);
    chk("ctrl resp", {30'h0, RESP_OKAY}, {30'h0, resp});
    chk("pd reset", 32'h1, {31'h0, patternTablePowerDown});
  endtask : t_reset

  task automatic t_gate_closed();
    axw(WORD_OFF, 32'h1234_5678, resp);
    chk("word wr no enable", {30'h0, RESP_SLVERR}, {30'h0, resp});
    axw(CTRL_OFF, 32'h0000_00c5, resp);
    axw(GATE_OFF, 32'h0000_1000, resp);
    chk("pd gate bit0 low", 32'h1, {31'h0, patternTablePowerDown});
    axw(WORD_OFF, 32'hdead_beef, resp);
    chk("word wr gate low", {30'h0, RESP_SLVERR}, {30'h0, resp});
    axr(WORD_OFF, rd, resp);
    chk("word rd gate low", {30'h0, RESP_SLVERR}, {30'h0, resp});
    axr(CTRL_OFF, rd, resp);
    chk("ctrl no increment", 32'h0000_00c5, rd);
  endtask : t_gate_closed

  task automatic t_half_enable();
    axw(GATE_OFF, 32'h0000_1001, resp);
    axw(CTRL_OFF, 32'h0000_0085, resp);
    chk("pd update low", 32'h1, {31'h0, patternTablePowerDown});
    axw(WORD_OFF, 32'h0bad_0bad, resp);
    chk("word wr update low", {30'h0, RESP_SLVERR}, {30'h0, resp});
    axw(CTRL_OFF, 32'h0000_0045, resp);
    axw(WORD_OFF, 32'h0bad_0bad, resp);
    chk("word wr access low", {30'h0, RESP_SLVERR}, {30'h0, resp});
    axr(WORD_OFF, rd, resp);
    chk("word rd access low", {30'h0, RESP_SLVERR}, {30'h0, resp});
    chk("refused rd data reg", 32'h0bad_0bad, rd);
    axr(CTRL_OFF, rd, resp);
    chk("ctrl held", 32'h0000_0045, rd);
  endtask : t_half_enable

  task automatic t_access();
    logic [31:0] pat [3];
    pat = '{32'ha5a5_0001, 32'h5a5a_0002, 32'hc3c3_0003};
    axw(CTRL_OFF, 32'h0000_00fe, resp);
    chk("pd open", 32'h0, {31'h0, patternTablePowerDown});
    for (int i = 0; i < 3; i++) begin
      axw(WORD_OFF, pat[i], resp);
      chk("word wr ok", {30'h0, RESP_OKAY}, {30'h0, resp});
    end
    axr(CTRL_OFF, rd, resp);
    chk("addr after wraps", 32'h0000_00c1, rd);
    axw(CTRL_OFF, 32'h0000_00fe, resp);
    for (int i = 0; i < 3; i++) begin
      axr(WORD_OFF, rd, resp);
      chk("word rd", pat[i], rd);
      chk("word rd ok", {30'h0, RESP_OKAY}, {30'h0, resp});
    end
    axr(CTRL_OFF, rd, resp);
    chk("addr after reads", 32'h0000_00c1, rd);
    axw(CTRL_OFF, 32'h0000_00ff, resp);
    axr(WORD_OFF, rd, resp);
    chk("reload selects word", pat[1], rd);
  endtask : t_access

  task automatic t_unmapped();
    axr(12'h408, rd, resp);
    chk("unmapped rd resp", {30'h0, RESP_DECERR}, {30'h0, resp});
    chk("unmapped rd data", 32'h0, rd);
    axw(12'h410, 32'hffff_ffff, resp);
    chk("unmapped wr resp", {30'h0, RESP_DECERR}, {30'h0, resp});
    axr(CTRL_OFF, rd, resp);
    chk("ctrl untouched", 32'h0000_00c0, rd);
  endtask : t_unmapped

  task automatic t_strobe();
    strbSel = 4'he;
    axw(CTRL_OFF, 32'h0000_0005, resp);
    strbSel = 4'h1;
    axw(WORD_OFF, 32'h0000_0077, resp);
    strbSel = 4'hf;
    chk("word wr partial ok", {30'h0, RESP_OKAY}, {30'h0, resp});
    axr(CTRL_OFF, rd, resp);
    chk("ctrl needs low strobe", 32'h0000_00c1, rd);
    axw(CTRL_OFF, 32'h0000_00c0, resp);
    axr(WORD_OFF, rd, resp);
    chk("merged word", 32'h5a5a_0077, rd);
  endtask : t_strobe

  task automatic t_rerst();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    axr(CTRL_OFF, rd, resp);
    chk("ctrl re-reset", 32'h0000_0000, rd);
    chk("pd re-reset", 32'h1, {31'h0, patternTablePowerDown});
    axr(GATE_OFF, rd, resp);
    chk("gate re-reset", 32'h0000_0000, rd);
  endtask : t_rerst

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_gate_closed();
    t_half_enable();
    t_access();
    t_unmapped();
    t_strobe();
    t_rerst();
    repeat (2) @(posedge clk);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
